/* shared/mic_pkg.sv */
// constants, types and register layout of the interrupt controller
//
// Notes on behaviour
// - ten request sources, each with its own flag bit in control or peripheral flags.
// - global enable at control bit 7 passes unmasked requests; clear blocks all.
// - every device reset clears the global enable.
// - taking a request clears global enable, pushes return, loads vector 0004h.
// - return-from-handler leaves the routine and sets global enable again.
// - latency three to four cycles asynchronous, exactly three synchronous.
// - latency is the same for one-cycle and two-cycle instructions.
// - each flag is set by its event regardless of any enable bit.
// - after global enable is cleared, one cycle ignores requests; they stay pending.
// - external pin edge triggered; option bit 6 picks rising, clear picks falling.
// - valid external edge sets control bit 1; masked by its enable bit.
// - external flag sampled every Q1; may be set during Q4 to Q1.
// - external source wakes from sleep if enabled; global enable decides vectoring.
// - timer zero rollover FFh to 00h sets control bit 2; enable bit 5.
// - change on port pins 7 to 4 sets control bit 0; own enable.
// - a change during a port read in Q2 may miss the flag.
// - peripheral flags at 0Ch, matching enables at 8Ch, same bit positions.
// - only the return address is saved on vectoring; nothing else.
// - enabled source wakes from sleep whatever the global enable.
package mic_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
   localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
   // control register fields
   localparam int CTL_GIE = 7;
   localparam int CTL_PERIPHERAL_GROUP_ENABLE = 6;
   localparam int CTL_TIMER0_OVERFLOW_ENABLE = 5;
   localparam int CTL_EXT_PIN_ENABLE = 4;
   localparam int CTL_PORT_CHANGE_ENABLE = 3;
   localparam int CTL_TIMER0_OVERFLOW_FLAG = 2;
   localparam int CTL_EXT_PIN_FLAG = 1;
   localparam int CTL_PORT_CHANGE_FLAG = 0;
   // option register field
   localparam int OPT_EDGE = 6;
   // reset values
   localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPH = 8'h00;
   localparam logic RST_EDGE_SEL = 1'b1;
   // bit 3 of the peripheral registers is unimplemented
   localparam logic [7:0] PERIPH_MASK = 8'hf7;
   // vector and timing
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [7:0] TIMER_ZERO_COUNT_TOP = 8'hff;
   localparam logic [7:0] TIMER_ZERO_COUNT_ZERO = 8'h00;
   localparam int CLK_PER_TCY = 4;
   localparam int LATENCY_TCY = 3;
   localparam logic [3:0] LAT_CLK = 4'(LATENCY_TCY * CLK_PER_TCY - 1);
   localparam logic [2:0] GUARD_CLK = 3'(CLK_PER_TCY);
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q4 = 2'h3;

   typedef enum logic [1:0] {MIC_IDLE, MIC_WAIT} mic_state_t;

   typedef struct packed {
      mic_state_t st;
      logic [7:0] ctrl;
      logic [7:0] pflag;
      logic [7:0] pen;
      logic edge_sel;
      logic ext_prev;
      logic ext_pend;
      logic [3:0] port_prev;
      logic [7:0] tmr_prev;
      logic [1:0] q;
      logic [3:0] lat;
      logic [2:0] guard;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq_req;
      logic vec_load;
      logic push_ret;
      logic [12:0] vec_addr;
      logic wake;
   } mic_regs_t;
endpackage

/* src/mic_irq_controller.sv */
// interrupt controller: flags, enables, request gating, vectoring and wake
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_controller #(
   parameter int ADDR_W = 12
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // event sources
   input wire logic ext_request_pin_i,
   input wire logic [7:0] timer_zero_count_i,
   input wire logic [3:0] port_upper_i,
   input wire logic port_read_i,
   input wire logic [7:0] periph_event_i,
   // core side
   input wire logic return_from_handler_i,
   input wire logic sleep_i,
   output logic irq_request_o,
   output logic vector_load_o,
   output logic push_return_o,
   output logic [12:0] vector_addr_o,
   output logic wake_o,
   output logic [1:0] q_phase_o
);
   mic_pkg::mic_regs_t st_r;
   mic_pkg::mic_regs_t st_nxt;

   // --------------------------------------------------------------
   // combinational decode of events and request
   // --------------------------------------------------------------
   logic setup_w;
   logic access_w;
   logic [7:0] idx_w;
   logic mapped_w;
   logic ext_edge_w;
   logic tmr_roll_w;
   logic port_chg_w;
   logic [7:0] pev_w;
   logic any_enabled_w;
   logic req_w;
   logic gie_cleared_w;

   // apb phases; the low two address bits must be zero, otherwise the access is unmapped
   assign setup_w = psel_i && !penable_i;
   assign access_w = psel_i && penable_i && st_r.pready;
   assign idx_w = paddr_i[9:2];
   assign mapped_w = (paddr_i[ADDR_W-1:10] == '0) && (paddr_i[1:0] == 2'h0) &&
      (idx_w == mic_pkg::IDX_IRQ_CONTROL || idx_w == mic_pkg::IDX_PERIPH_FLAGS ||
       idx_w == mic_pkg::IDX_OPTION || idx_w == mic_pkg::IDX_PERIPH_ENABLES);

   // edge picked by the select bit
   assign ext_edge_w = st_r.edge_sel ? (ext_request_pin_i && !st_r.ext_prev)
                                     : (!ext_request_pin_i && st_r.ext_prev);
   // only a wrap from top to zero counts
   assign tmr_roll_w = (st_r.tmr_prev == mic_pkg::TIMER_ZERO_COUNT_TOP) &&
                       (timer_zero_count_i == mic_pkg::TIMER_ZERO_COUNT_ZERO);
   // a change while the port is read in Q2 is swallowed
   assign port_chg_w = (port_upper_i != st_r.port_prev) &&
                       !(port_read_i && st_r.q == mic_pkg::Q2);
   assign pev_w = periph_event_i & mic_pkg::PERIPH_MASK;

   // enabled sources regardless of the global enable
   assign any_enabled_w =
      (st_r.ctrl[mic_pkg::CTL_TIMER0_OVERFLOW_ENABLE] && st_r.ctrl[mic_pkg::CTL_TIMER0_OVERFLOW_FLAG]) ||
      (st_r.ctrl[mic_pkg::CTL_EXT_PIN_ENABLE] && st_r.ctrl[mic_pkg::CTL_EXT_PIN_FLAG]) ||
      (st_r.ctrl[mic_pkg::CTL_PORT_CHANGE_ENABLE] && st_r.ctrl[mic_pkg::CTL_PORT_CHANGE_FLAG]) ||
      (st_r.ctrl[mic_pkg::CTL_PERIPHERAL_GROUP_ENABLE] && |(st_r.pflag & st_r.pen));
   // request gated by the global enable
   assign req_w = st_r.ctrl[mic_pkg::CTL_GIE] && any_enabled_w;
   // a software write that drops the global enable
   assign gie_cleared_w = access_w && pwrite_i && mapped_w &&
      (idx_w == mic_pkg::IDX_IRQ_CONTROL) && st_r.ctrl[mic_pkg::CTL_GIE] &&
      !pwdata_i[mic_pkg::CTL_GIE];

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.vec_load = 1'b0;
      st_nxt.push_ret = 1'b0;
      st_nxt.q = st_r.q + 2'h1;
      st_nxt.ext_prev = ext_request_pin_i;
      st_nxt.tmr_prev = timer_zero_count_i;
      st_nxt.port_prev = port_upper_i;
      if (st_r.guard != 3'h0) begin
         st_nxt.guard = st_r.guard - 3'h1;
      end

      // apb: answer in the cycle after setup, write lands at that edge
      if (setup_w) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !mapped_w;
         st_nxt.prdata = 32'h0000_0000;
         if (!pwrite_i && mapped_w) begin
            case (idx_w)
               mic_pkg::IDX_IRQ_CONTROL: st_nxt.prdata[7:0] = st_r.ctrl;
               // flags and enables at matching positions
               mic_pkg::IDX_PERIPH_FLAGS: st_nxt.prdata[7:0] = st_r.pflag;
               mic_pkg::IDX_PERIPH_ENABLES: st_nxt.prdata[7:0] = st_r.pen;
               mic_pkg::IDX_OPTION: st_nxt.prdata[mic_pkg::OPT_EDGE] = st_r.edge_sel;
               default: st_nxt.prdata = 32'h0000_0000;
            endcase
         end
      end else begin
         st_nxt.pready = 1'b0;
         st_nxt.pslverr = 1'b0;
      end
      if (access_w && pwrite_i && mapped_w) begin
         case (idx_w)
            mic_pkg::IDX_IRQ_CONTROL: st_nxt.ctrl = pwdata_i[7:0];
            mic_pkg::IDX_PERIPH_FLAGS: st_nxt.pflag = pwdata_i[7:0] & mic_pkg::PERIPH_MASK;
            mic_pkg::IDX_PERIPH_ENABLES: st_nxt.pen = pwdata_i[7:0] & mic_pkg::PERIPH_MASK;
            mic_pkg::IDX_OPTION: st_nxt.edge_sel = pwdata_i[mic_pkg::OPT_EDGE];
            default: st_nxt.edge_sel = st_r.edge_sel;
         endcase
      end

      // one instruction cycle in which requests are ignored
      if (gie_cleared_w) begin
         st_nxt.guard = mic_pkg::GUARD_CLK;
      end

      // return from handler sets the global enable again
      if (return_from_handler_i) begin
         st_nxt.ctrl[mic_pkg::CTL_GIE] = 1'b1;
      end

      // hardware sets come after the software write so a set wins over a clear
      // an edge outside Q4..Q1 waits in a pending bit for the window
      if (ext_edge_w || st_r.ext_pend) begin
         if (st_r.q == mic_pkg::Q4 || st_r.q == mic_pkg::Q1) begin
            // valid edge sets the external flag
            st_nxt.ctrl[mic_pkg::CTL_EXT_PIN_FLAG] = 1'b1;
            st_nxt.ext_pend = 1'b0;
         end else begin
            st_nxt.ext_pend = 1'b1;
         end
      end
      if (tmr_roll_w) begin
         st_nxt.ctrl[mic_pkg::CTL_TIMER0_OVERFLOW_FLAG] = 1'b1;
      end
      if (port_chg_w) begin
         st_nxt.ctrl[mic_pkg::CTL_PORT_CHANGE_FLAG] = 1'b1;
      end
      // peripheral flags collect the remaining sources
      st_nxt.pflag = st_nxt.pflag | pev_w;

      // vectoring sequencer, counted in clocks so instruction length is irrelevant
      case (st_r.st)
         mic_pkg::MIC_IDLE: begin
            if (st_r.q == mic_pkg::Q1 && req_w && st_r.guard == 3'h0 && !gie_cleared_w) begin
               st_nxt.st = mic_pkg::MIC_WAIT;
               // the registered pulse adds one clock, so the count starts one lower
               st_nxt.lat = mic_pkg::LAT_CLK - 4'h1;
            end
         end
         mic_pkg::MIC_WAIT: begin
            // dropping the global enable abandons the attempt, flag stays
            if (!st_r.ctrl[mic_pkg::CTL_GIE] || gie_cleared_w || st_r.guard != 3'h0) begin
               st_nxt.st = mic_pkg::MIC_IDLE;
            // fixed latency from the sampling Q1; no instruction input
            end else if (st_r.lat == 4'h0) begin
               st_nxt.st = mic_pkg::MIC_IDLE;
               // clear global enable, push return, load vector
               st_nxt.ctrl[mic_pkg::CTL_GIE] = 1'b0;
               // the return address push is all that is saved
               st_nxt.push_ret = 1'b1;
               st_nxt.vec_load = 1'b1;
               st_nxt.vec_addr = mic_pkg::IRQ_VECTOR;
            end else begin
               st_nxt.lat = st_r.lat - 4'h1;
            end
         end
         default: st_nxt.st = mic_pkg::MIC_IDLE;
      endcase

      // registered request level to the core
      st_nxt.irq_req = st_nxt.ctrl[mic_pkg::CTL_GIE] && any_enabled_w;
      // wake from sleep on any enabled source, global enable not involved
      st_nxt.wake = sleep_i && any_enabled_w;

      // every reset clears the global enable
      if (sys_rst_i) begin
         st_nxt = '0;
         st_nxt.st = mic_pkg::MIC_IDLE;
         st_nxt.ctrl = mic_pkg::RST_IRQ_CONTROL;
         st_nxt.pflag = mic_pkg::RST_PERIPH;
         st_nxt.pen = mic_pkg::RST_PERIPH;
         st_nxt.edge_sel = mic_pkg::RST_EDGE_SEL;
         st_nxt.vec_addr = mic_pkg::IRQ_VECTOR;
         // history follows the live inputs so release shows no false edge
         st_nxt.ext_prev = ext_request_pin_i;
         st_nxt.tmr_prev = timer_zero_count_i;
         st_nxt.port_prev = port_upper_i;
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   // synchronous reset only, so one plain register for the whole state
   always_ff @(posedge clock_i) begin
      st_r <= st_nxt;
   end

   // outputs straight from the state flops
   assign prdata_o = st_r.prdata;
   assign pready_o = st_r.pready;
   assign pslverr_o = st_r.pslverr;
   assign irq_request_o = st_r.irq_req;
   assign vector_load_o = st_r.vec_load;
   assign push_return_o = st_r.push_ret;
   assign vector_addr_o = st_r.vec_addr;
   assign wake_o = st_r.wake;
   assign q_phase_o = st_r.q;

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   a_gie_after_reset: assert property (
      $fell(sys_rst_i) |-> !st_r.ctrl[mic_pkg::CTL_GIE])
      else $error("global enable set right after reset");

   a_vector_clears_gie: assert property (
      vector_load_o |-> push_return_o && !st_r.ctrl[mic_pkg::CTL_GIE] &&
         vector_addr_o == 13'h0004)
      else $error("vectoring without push, clear or right address");

   a_return_from_handler_sets_gie: assert property (
      return_from_handler_i && !(st_r.st == mic_pkg::MIC_WAIT && st_r.lat == 4'h0)
      |=> st_r.ctrl[mic_pkg::CTL_GIE])
      else $error("return did not set global enable");

   sequence s_wait_start;
      st_r.st == mic_pkg::MIC_IDLE ##1 st_r.st == mic_pkg::MIC_WAIT;
   endsequence

   a_latency_fixed: assert property (
      s_wait_start |-> st_r.lat == mic_pkg::LAT_CLK - 4'h1)
      else $error("latency count not loaded on sampling");

   a_wait_to_vector: assert property (
      st_r.st == mic_pkg::MIC_WAIT && st_r.lat == 4'h0 && st_r.ctrl[mic_pkg::CTL_GIE] &&
         st_r.guard == 3'h0 && !gie_cleared_w |=> vector_load_o)
      else $error("vector not issued when the latency count ran out");

   a_vector_at_q: assert property (
      vector_load_o |-> q_phase_o == 2'h0 && $past(st_r.st, 12) == mic_pkg::MIC_IDLE)
      else $error("vector off the instruction cycle grid");

   a_tmr_flag: assert property (
      $past(timer_zero_count_i) == 8'hff && timer_zero_count_i == 8'h00
      |=> st_r.ctrl[mic_pkg::CTL_TIMER0_OVERFLOW_FLAG])
      else $error("timer rollover did not set its flag");

   a_guard_blocks: assert property (
      gie_cleared_w |=> !vector_load_o [*4])
      else $error("request taken in the guard cycle");

   a_ext_window: assert property (
      $rose(st_r.ctrl[mic_pkg::CTL_EXT_PIN_FLAG]) |-> $past(st_r.q) == 2'h3 || $past(st_r.q) == 2'h0)
      else $error("external flag set outside Q4 to Q1");

   a_port_flag: assert property (
      port_upper_i != st_r.port_prev && !port_read_i |=> st_r.ctrl[mic_pkg::CTL_PORT_CHANGE_FLAG])
      else $error("port change did not set its flag");

   a_wake_any: assert property (
      sleep_i && any_enabled_w |=> wake_o)
      else $error("enabled source did not wake");

   a_req_gated: assert property (
      irq_request_o |-> st_r.ctrl[mic_pkg::CTL_GIE] && $past(any_enabled_w))
      else $error("request raised without global enable");

   a_apb_ready: assert property (
      setup_w |=> pready_o ##1 !pready_o || setup_w)
      else $error("apb answer not one cycle after setup");

   c_vector_taken: cover property (vector_load_o);
   c_wake_seen: cover property (sleep_i ##1 wake_o);
   c_guard_abort: cover property (st_r.st == mic_pkg::MIC_WAIT ##1 gie_cleared_w);
   c_return_from_handler_again: cover property (vector_load_o ##[1:200] return_from_handler_i);
endmodule
`default_nettype wire

/* test/mic_core_model.sv */
// behavioural model of the instruction core facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic vector_load_i,
   input wire logic push_return_i,
   input wire logic [12:0] vector_addr_i,
   input wire logic ret_cmd_i,
   output logic return_from_handler_o,
   output logic [7:0] vec_count_o,
   output logic [12:0] pc_o
);
   logic [12:0] stack_q[$];
   // ----------------------------------------
   // program counter, return stack, handler exit
   // ----------------------------------------
   // the pc stands still: only vectoring and handler exit move it, so a wrong
   // return address shows up directly in pc_o
   always @(posedge clock_i) begin
      return_from_handler_o <= 1'b0;
      if (sys_rst_i) begin
         pc_o <= 13'h0100;
         vec_count_o <= 8'h00;
         stack_q.delete();
      end else if (vector_load_i && push_return_i) begin
         // push only the return pc, then load the vector
         stack_q.push_back(pc_o);
         pc_o <= vector_addr_i;
         vec_count_o <= vec_count_o + 8'h01;
      end else if (ret_cmd_i && stack_q.size() > 0) begin
         // handler exit pulse re-arms the global enable
         pc_o <= stack_q.pop_back();
         return_from_handler_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* test/mic_irq_controller_tb_top.sv */
// self-checking bench: apb master, event sources and a core model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch %0t: got %h exp %h", $time, a, b); end end
module mic_irq_controller_tb_top;
   localparam logic [11:0] A_CTL = 12'({mic_pkg::IDX_IRQ_CONTROL, 2'b00});
   localparam logic [11:0] A_PFL = 12'({mic_pkg::IDX_PERIPH_FLAGS, 2'b00});
   localparam logic [11:0] A_PEN = 12'({mic_pkg::IDX_PERIPH_ENABLES, 2'b00});
   localparam logic [11:0] A_OPT = 12'({mic_pkg::IDX_OPTION, 2'b00});
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata_o;
   logic pready_o, pslverr_o, irq_request_o, vector_load_o, push_return_o, wake_o;
   logic ext = 1'b0, pread = 1'b0, sleep = 1'b0, ret_cmd = 1'b0, rfh;
   logic [7:0] tmr = 8'h10, pev = 8'h00, vcnt, v0;
   logic [3:0] port = 4'h0;
   logic [12:0] vaddr, core_pc;
   logic [1:0] qph;
   logic [32:0] rdq[$];
   logic [32:0] exp_rd;
   int miscompares = 0, cmp_count = 0, cyc = 0, seed, n, r;

   mic_irq_controller i_mic_irq_controller (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ext_request_pin_i(ext), .timer_zero_count_i(tmr), .port_upper_i(port),
      .port_read_i(pread), .periph_event_i(pev), .return_from_handler_i(rfh),
      .sleep_i(sleep), .irq_request_o(irq_request_o), .vector_load_o(vector_load_o),
      .push_return_o(push_return_o), .vector_addr_o(vaddr), .wake_o(wake_o),
      .q_phase_o(qph));
   mic_core_model i_mic_core_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .vector_load_i(vector_load_o), .push_return_i(push_return_o), .vector_addr_i(vaddr),
      .ret_cmd_i(ret_cmd), .return_from_handler_o(rfh), .vec_count_o(vcnt), .pc_o(core_pc));

   // ----------------------------------------
   // clock, timeout and read monitor
   // ----------------------------------------
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // reads are judged at the edge where pready is sampled, against the oldest note
   always @(posedge clock_i) begin
      if (psel && penable && !pwrite && pready_o === 1'b1) begin
         if (rdq.size() == 0) miscompares++;
         else begin
            exp_rd = rdq.pop_front();
            `CHK({pslverr_o, prdata_o}, exp_rd)
         end
      end
   end

   // ----------------------------------------
   // bus and event tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [32:0] e);
      int k;
      k = 0;
      @(posedge clock_i);
      if (!w) rdq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, {25'h0, e});
   endtask
   task automatic wait_clk(input int c);
      repeat (c) @(posedge clock_i);
   endtask
   // bounded wait for the core model to register a vector
   task automatic wait_vec(output int c);
      logic [7:0] v;
      v = vcnt;
      c = 0;
      while (vcnt === v && c < 40) begin
         @(posedge clock_i);
         c++;
      end
   endtask
   task automatic do_ret;
      @(posedge clock_i);
      ret_cmd <= 1'b1;
      @(posedge clock_i);
      ret_cmd <= 1'b0;
      wait_clk(3);
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 15;
      wait_clk(12);
      sys_rst_i <= 1'b0;
      rd(A_CTL, 8'h00);
      rd(A_PFL, 8'h00);
      rd(A_OPT, 8'h40);
      apb(1'b0, 12'h3fc, 8'h00, {1'b1, 32'h0});
      // timer rollover with global and timer enables set
      wr(A_CTL, 8'ha0);
      @(posedge clock_i);
      tmr <= 8'hff;
      @(posedge clock_i);
      tmr <= 8'h00;
      wait_vec(n);
      // flag edge, next Q1 sample, twelve clocks, then the model's edge
      `CHK(1'(n >= 15 && n <= 18), 1'b1)
      `CHK(core_pc, 13'h0004)
      rd(A_CTL, 8'h24);
      // handler clears its flag before re-arming through the exit pulse
      wr(A_CTL, 8'h20);
      v0 = vcnt;
      do_ret();
      `CHK(core_pc, 13'h0100)
      rd(A_CTL, 8'ha0);
      // peripheral flags set with every enable clear
      wr(A_CTL, 8'h00);
      @(posedge clock_i);
      pev <= 8'hff;
      @(posedge clock_i);
      pev <= 8'h00;
      rd(A_PFL, 8'hf7);
      r = $random(seed);
      wr(A_PEN, r[7:0]);
      rd(A_PEN, r[7:0] & mic_pkg::PERIPH_MASK);
      wr(A_PEN, 8'hf7);
      wr(A_CTL, 8'h80);
      wait_clk(20);
      `CHK(irq_request_o, 1'b0)
      `CHK(vcnt, v0)
      wr(A_CTL, 8'hc0);
      wait_vec(n);
      `CHK(vcnt, v0 + 8'h01)
      rd(A_CTL, 8'h40);
      wr(A_PFL, 8'h00);
      do_ret();
      rd(A_CTL, 8'hc0);
      // falling-edge select: a rising edge must be ignored
      wr(A_OPT, 8'h00);
      ext <= 1'b1;
      wait_clk(8);
      rd(A_CTL, 8'hc0);
      ext <= 1'b0;
      wait_clk(8);
      rd(A_CTL, 8'hc2);
      port <= 4'h5;
      wait_clk(8);
      rd(A_CTL, 8'hc3);
      `CHK(vcnt, v0 + 8'h01)
      // a port change during a core read in Q2 is lost, outside Q2 it counts
      wr(A_CTL, 8'hc0);
      pread <= 1'b1;
      while (qph !== 2'h0) @(posedge clock_i);
      port <= 4'ha;
      wait_clk(8);
      rd(A_CTL, 8'hc0);
      while (qph !== 2'h3) @(posedge clock_i);
      port <= 4'h5;
      wait_clk(8);
      rd(A_CTL, 8'hc1);
      pread <= 1'b0;
      // asleep with only the pin enabled and the global enable clear
      wr(A_CTL, 8'h10);
      sleep <= 1'b1;
      wr(A_OPT, 8'h40);
      ext <= 1'b1;
      wait_clk(8);
      `CHK(wake_o, 1'b1)
      `CHK(irq_request_o, 1'b0)
      wait_clk(20);
      `CHK(vcnt, v0 + 8'h01)
      `CHK(rdq.size(), 0)
      stop_test();
   end
endmodule
`default_nettype wire
